// ### ssc_pkg.sv
// Package for the shutdown switch control block
package ssc_pkg;
  // Register offsets on the plain port
  localparam logic [3:0] SSC_SHUTDOWN_OFS = 4'h0;
  localparam logic [3:0] SSC_CONFIG_OFS   = 4'h1;
  // Field positions
  localparam int SSC_LASER_LSB = 0;
  localparam int SSC_TEC_LSB   = 2;
  localparam int SSC_SOFT_LSB  = 0;
  localparam int SSC_POL_LSB   = 2;
  // Values after reset, then the off, soft-off and bipolar codes
  localparam logic [1:0] SSC_LASER_RST = 2'h0;
  localparam logic [1:0] SSC_TEC_RST   = 2'h0;
  localparam logic [1:0] SSC_SOFT_RST  = 2'h3;
  localparam logic [1:0] SSC_POL_RST   = 2'h0;
  localparam logic [1:0] SSC_OFF_CODE  = 2'h0;
  localparam logic [1:0] SSC_SOFT_OFF  = 2'h0;
  localparam logic [1:0] SSC_POL_BIP   = 2'h0;

  // Switch positions travelling together
  typedef struct packed {
    logic laser_connected;
    logic tec_connected;
    logic bias_is_ref;
    logic soft_closed;
  } ssc_switch_t;
endpackage

// ### ssc_switch_ctrl.sv
// Register-driven control of the four shutdown switches
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module ssc_switch_ctrl
  import ssc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // Switch controls
  output ssc_switch_t      switch_out,
  output logic             laser_switch_off_out,
  output logic             tec_switch_off_out,
  output logic             soft_start_request_out,
  output logic             integrator_to_drive_out
);

  logic [1:0]  laser_field_reg;
  logic [1:0]  tec_field_reg;
  logic [1:0]  soft_field_reg;
  logic [1:0]  pol_field_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Address decode
  wire wr_shut = wr_in && (addr_in == SSC_SHUTDOWN_OFS);
  wire wr_conf = wr_in && (addr_in == SSC_CONFIG_OFS);

  // Register write, reset to defaults
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      laser_field_reg <= SSC_LASER_RST;
      tec_field_reg   <= SSC_TEC_RST;
      soft_field_reg  <= SSC_SOFT_RST;
      pol_field_reg   <= SSC_POL_RST;
    end else begin
      if (wr_shut) begin
        laser_field_reg <= wdata_in[SSC_LASER_LSB +: 2];
        tec_field_reg   <= wdata_in[SSC_TEC_LSB +: 2];
      end
      if (wr_conf) begin
        soft_field_reg <= wdata_in[SSC_SOFT_LSB +: 2];
        pol_field_reg  <= wdata_in[SSC_POL_LSB +: 2];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (rd_in && addr_in == SSC_SHUTDOWN_OFS) begin
      rdata_next = {12'h000, tec_field_reg, laser_field_reg};
    end else if (rd_in && addr_in == SSC_CONFIG_OFS) begin
      rdata_next = {12'h000, pol_field_reg, soft_field_reg};
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Switch decode
  wire laser_off = (laser_field_reg == SSC_OFF_CODE);
  wire tec_off   = (tec_field_reg == SSC_OFF_CODE);
  wire soft_req  = (soft_field_reg != SSC_SOFT_OFF);
  wire bias_ref  = (pol_field_reg == SSC_POL_BIP);

  // Output drive
  assign rdata_out               = rdata_reg;
  assign laser_switch_off_out    = laser_off;
  assign tec_switch_off_out      = tec_off;
  assign soft_start_request_out  = soft_req;
  assign integrator_to_drive_out = !tec_off;
  assign switch_out.laser_connected = !laser_off;
  assign switch_out.tec_connected   = !tec_off;
  assign switch_out.bias_is_ref     = bias_ref;
  assign switch_out.soft_closed     = tec_off && soft_req;

  // Checks
  property p_soft_open;
    @(posedge clock_in) disable iff (rst_in)
      (wr_conf && wdata_in[1:0] == 2'h0) |=> !switch_out.soft_closed;
  endproperty
  a_soft_open: assert property (p_soft_open) else $error("soft open");

  property p_laser;
    @(posedge clock_in) disable iff (rst_in)
      (wr_shut && wdata_in[1:0] == 2'h0) |=> laser_switch_off_out;
  endproperty
  a_laser: assert property (p_laser) else $error("laser off");

  property p_tec;
    @(posedge clock_in) disable iff (rst_in)
      (wr_shut && wdata_in[3:2] != 2'h0) |=> !tec_switch_off_out;
  endproperty
  a_tec: assert property (p_tec) else $error("tec on");

  property p_pol;
    @(posedge clock_in) disable iff (rst_in)
      wr_conf |=> (switch_out.bias_is_ref == ($past(wdata_in[3:2]) == 2'h0));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");

  property p_drive;
    @(posedge clock_in) disable iff (rst_in)
      integrator_to_drive_out == switch_out.tec_connected;
  endproperty
  a_drive: assert property (p_drive) else $error("drive path");

  property p_soft_mix;
    @(posedge clock_in) disable iff (rst_in)
      switch_out.soft_closed |-> (tec_switch_off_out && soft_start_request_out);
  endproperty
  a_soft_mix: assert property (p_soft_mix) else $error("soft mix");

  property p_hold;
    @(posedge clock_in) disable iff (rst_in)
      !wr_in |=> $stable(switch_out);
  endproperty
  a_hold: assert property (p_hold) else $error("switch moved");

  property p_rst;
    @(posedge clock_in) $fell(rst_in) |->
      (switch_out == 4'h3 && laser_switch_off_out);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");

  property p_rd;
    @(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == SSC_CONFIG_OFS) |=>
        rdata_out[3:0] == {$past(pol_field_reg), $past(soft_field_reg)};
  endproperty
  a_rd: assert property (p_rd) else $error("read back");

  // Read data is zero in every cycle that follows no read
  property p_rd_idle;
    @(posedge clock_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");

  // Shutdown read returns both switch fields
  property p_rd_shut;
    @(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == SSC_SHUTDOWN_OFS) |=>
        rdata_out == {12'h000, $past(tec_field_reg), $past(laser_field_reg)};
  endproperty
  a_rd_shut: assert property (p_rd_shut) else $error("shut read");

  // Unmapped reads return zero
  property p_rd_unmapped;
    @(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in > SSC_CONFIG_OFS) |=> rdata_out == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");

  // Upper read bits never carry data
  property p_rd_upper;
    @(posedge clock_in) disable iff (rst_in)
      rdata_out[15:4] == 12'h000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");

  // Any non-off laser code enables the setpoint switch
  property p_laser_on;
    @(posedge clock_in) disable iff (rst_in)
      (wr_shut && wdata_in[1:0] != 2'h0) |=> !laser_switch_off_out;
  endproperty
  a_laser_on: assert property (p_laser_on) else $error("laser on");

  // Off code on the cooler field disables the drive switch
  property p_tec_off;
    @(posedge clock_in) disable iff (rst_in)
      (wr_shut && wdata_in[3:2] == 2'h0) |=> tec_switch_off_out;
  endproperty
  a_tec_off: assert property (p_tec_off) else $error("tec off");

  // Any non-zero soft code raises the request
  property p_soft_req;
    @(posedge clock_in) disable iff (rst_in)
      (wr_conf && wdata_in[1:0] != 2'h0) |=> soft_start_request_out;
  endproperty
  a_soft_req: assert property (p_soft_req) else $error("soft req");

  // Zero soft code drops the request
  property p_soft_nreq;
    @(posedge clock_in) disable iff (rst_in)
      (wr_conf && wdata_in[1:0] == 2'h0) |=> !soft_start_request_out;
  endproperty
  a_soft_nreq: assert property (p_soft_nreq) else $error("soft nreq");

  // Cooler off with request pending closes the soft-start switch
  property p_soft_close;
    @(posedge clock_in) disable iff (rst_in)
      (tec_switch_off_out && soft_start_request_out) |-> switch_out.soft_closed;
  endproperty
  a_soft_close: assert property (p_soft_close) else $error("soft close");

  // Laser connection is the inverse of its switch-off signal
  property p_laser_conn;
    @(posedge clock_in) disable iff (rst_in)
      switch_out.laser_connected == !laser_switch_off_out;
  endproperty
  a_laser_conn: assert property (p_laser_conn) else $error("laser conn");

  // Writes to unmapped offsets leave every switch alone
  property p_wr_unmapped;
    @(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in > SSC_CONFIG_OFS) |=> $stable(switch_out);
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("wr unmap");

  // Reset leaves cooler off, request up and integrator cut off
  property p_rst_out;
    @(posedge clock_in) $fell(rst_in) |->
      (tec_switch_off_out && soft_start_request_out &&
       !integrator_to_drive_out);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outs");

  // Reset selects the reference for the bias switch
  property p_rst_bias;
    @(posedge clock_in) $fell(rst_in) |-> switch_out.bias_is_ref;
  endproperty
  a_rst_bias: assert property (p_rst_bias) else $error("reset bias");

  // Reset clears the read data
  property p_rst_rd;
    @(posedge clock_in) $fell(rst_in) |-> rdata_out == 16'h0000;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("reset rdata");

  // A shutdown write leaves the configuration outputs alone
  property p_shut_only;
    @(posedge clock_in) disable iff (rst_in)
      wr_shut |=> ($stable(switch_out.bias_is_ref) &&
                   $stable(soft_start_request_out));
  endproperty
  a_shut_only: assert property (p_shut_only) else $error("shut only");

  // A configuration write leaves the switch-off signals alone
  property p_conf_only;
    @(posedge clock_in) disable iff (rst_in)
      wr_conf |=> ($stable(laser_switch_off_out) &&
                   $stable(tec_switch_off_out));
  endproperty
  a_conf_only: assert property (p_conf_only) else $error("conf only");

  // Drive switch off cuts the integrator from the drive output
  property p_drive_off;
    @(posedge clock_in) disable iff (rst_in)
      tec_switch_off_out |-> !integrator_to_drive_out;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive off");

  // Cooler connection is the inverse of its switch-off signal
  property p_tec_conn;
    @(posedge clock_in) disable iff (rst_in)
      switch_out.tec_connected == !tec_switch_off_out;
  endproperty
  a_tec_conn: assert property (p_tec_conn) else $error("tec conn");

  // Bipolar code puts the bias switch on the reference
  property p_bias_ref;
    @(posedge clock_in) disable iff (rst_in)
      (wr_conf && wdata_in[3:2] == 2'h0) |=> switch_out.bias_is_ref;
  endproperty
  a_bias_ref: assert property (p_bias_ref) else $error("bias ref");

  // Soft start only runs while the integrator is cut off
  property p_soft_drive;
    @(posedge clock_in) disable iff (rst_in)
      switch_out.soft_closed |-> !integrator_to_drive_out;
  endproperty
  a_soft_drive: assert property (p_soft_drive) else $error("soft drive");

  // Main scenarios
  c_soft: cover property (@(posedge clock_in)
    wr_conf ##1 !switch_out.soft_closed);
  c_tec_on: cover property (@(posedge clock_in)
    wr_shut ##1 integrator_to_drive_out);
  c_unipolar: cover property (@(posedge clock_in) !switch_out.bias_is_ref);
  c_rd_conf: cover property (@(posedge clock_in)
    rd_in && addr_in == SSC_CONFIG_OFS);
  c_laser_on: cover property (@(posedge clock_in)
    wr_shut ##1 !laser_switch_off_out);

endmodule

// ### ssc_switch_ctrl_tb_top.sv
// Self-checking testbench for the shutdown switch control block
`timescale 1ns/1ps
module ssc_switch_ctrl_tb_top
  import ssc_pkg::*;
;
  logic        clock_in, rst_in, wr_in, rd_in;
  logic [3:0]  addr_in;
  logic [15:0] wdata_in, rdata_out;
  ssc_switch_t switch_out;
  logic        lo, tof, rq, itg;
  int          mismatches, checks_done, seed, sh, cf, i;

  ssc_switch_ctrl DUT (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .switch_out(switch_out),
    .laser_switch_off_out(lo), .tec_switch_off_out(tof),
    .soft_start_request_out(rq), .integrator_to_drive_out(itg));

  // Clock at 40 MHz
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Expected switch vector from the model registers
  function automatic logic [7:0] model();
    logic l, t, r;
    l = (sh[1:0] == 0);
    t = (sh[3:2] == 0);
    r = (cf[1:0] != 0);
    return {~l, ~t, cf[3:2] == 0, t & r, l, t, r, ~t};
  endfunction

  // Compare tasks, one per kind of result
  task automatic cmp_out();
    checks_done++;
    if ({switch_out, lo, tof, rq, itg} !== model()) begin
      mismatches++;
      $display("[ERR] %0t got=%h exp=%h", $time,
               {switch_out, lo, tof, rq, itg}, model());
    end
  endtask
  task automatic cmp_rd(input logic [15:0] exp);
    checks_done++;
    if (rdata_out !== exp) begin
      mismatches++;
      $display("[ERR] %0t got=%h exp=%h", $time, rdata_out, exp);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
    if (a == SSC_SHUTDOWN_OFS) sh = d[3:0];
    if (a == SSC_CONFIG_OFS) cf = d[3:0];
    @(negedge clock_in);
    cmp_out();
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    cmp_rd(a == 0 ? 16'(sh) : a == 1 ? 16'(cf) : 16'h0000);
  endtask

  // Closing report
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h3CBE;
    rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0;
    addr_in = 4'h0; wdata_in = 16'h0000;
    sh = 0; cf = 3;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    cmp_out();
    rd(4'h0); rd(4'h1); rd(4'h7);
    for (i = 0; i < 4; i++) begin
      wr(4'h0, 16'(i * 5));
      wr(4'h1, 16'(i * 5));
      rd(4'h0); rd(4'h1);
    end
    wr(4'h0, 16'h0003); wr(4'h1, 16'h0003);
    wr(4'h1, 16'h0000);
    for (i = 0; i < 40; i++) begin
      wr(4'($random(seed) & 3), 16'($random(seed)));
      rd(4'($random(seed) & 3));
    end
    @(posedge clock_in);
    rst_in <= 1'b1;
    sh = 0; cf = 3;
    @(negedge clock_in);
    cmp_out();
    @(posedge clock_in);
    rst_in <= 1'b0;
    rd(4'h1);
    report_and_stop();
  end
endmodule
